// ==== sim/aofpm_ctrl_model.sv ====
// controller and capture-side model: drives the mode pins, resolves the data bus
`timescale 1ns/100ps
module aofpm_ctrl_model
    import aofpm_pkg::*;
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    // requested pin levels and device outputs
    input  wire aofpm_pins_t       i_want,
    input  wire logic [CODE_W-1:0] i_data,
    input  wire logic              i_data_oe,
    // pins to the device, bus as the capture logic sees it
    output aofpm_pins_t            o_pins,
    output logic      [CODE_W-1:0] o_bus
);
    logic [1:0]        init_r;
    logic [CODE_W-1:0] last_r;
    // power-down held low through power-up and three clocks after it
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            init_r <= 2'h0;
        end else if (init_r != 2'h3) begin
            init_r <= init_r + 2'h1;
        end
    end
    // reset pulse overrides the request; clock is never stopped here
    always_comb begin
        o_pins = i_want;
        if (init_r != 2'h3) begin
            o_pins.power_down_n = 1'b0;
        end
    end
    // a floating bus shows the inverse of the last driven word, so stale data cannot match
    always_ff @(posedge i_ref_clk) begin
        if (i_data_oe) begin
            last_r <= i_data;
        end
    end
    assign o_bus = i_data_oe ? i_data : ~last_r;
endmodule

// ==== sim/testbench.sv ====
// self-checking bench: clipping, formats, power modes and registers
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module testbench
    import aofpm_pkg::*;
;
    logic clk, nrst, irq, oe, ovr, und, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [CORE_W-1:0] core, off;
    logic [CODE_W-1:0] data, bus;
    logic [ADDR_W-1:0] awa, ara;
    logic [DATA_W-1:0] wd, rd;
    logic [1:0]        bresp, rresp, r;
    logic [DATA_W-1:0] d;
    logic [CODE_W+1:0] exp_q[$], e, last_e;
    logic [31:0]       seed;
    aofpm_pins_t       want, pins;
    logic              fmt;
    logic [CORE_W-1:0] bnd[8] = '{12'h000, 12'h01f, 12'h020, 12'h21f, 12'h220, 12'h41f, 12'h420, 12'hfff};
    int                n_fail, tests_run, cyc, t0, n_pd, n_sl;
    event              got;
    aofpm_top u_aofpm_top (.i_ref_clk(clk), .i_nrst(nrst), .i_core_code(core), .i_pins(pins), .o_data(data),
        .o_data_oe(oe), .o_over_range(ovr), .o_under_range(und), .o_irq(irq), .i_axi_awvalid(awv),
        .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wr), .i_axi_wdata(wd),
        .i_axi_wstrb(4'hf), .o_axi_bvalid(bv), .i_axi_bready(br), .o_axi_bresp(bresp), .i_axi_arvalid(arv),
        .o_axi_arready(arr), .i_axi_araddr(ara), .o_axi_rvalid(rv), .i_axi_rready(rr), .o_axi_rdata(rd),
        .o_axi_rresp(rresp));
    aofpm_ctrl_model u_aofpm_ctrl_model (.i_ref_clk(clk), .i_nrst(nrst), .i_want(want), .i_data(data),
        .i_data_oe(oe), .o_pins(pins), .o_bus(bus));
    // free-running clock, also through idle modes
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v, input logic [1:0] er);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= v; br <= 1'b1;
        for (int k = 0; k < 100; k++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) begin
                br <= 1'b0;
                `CHK(bresp, er)
                @(posedge clk);
                return;
            end
        end
        n_fail++;
        report_and_stop();
    endtask
    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        for (int k = 0; k < 100; k++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) begin
                rr <= 1'b0;
                d = rd;
                r = rresp;
                @(posedge clk);
                return;
            end
        end
        n_fail++;
        report_and_stop();
    endtask
    // poll status until active, counting clocks since t0
    task automatic wait_act(output int n);
        for (int k = 0; k < 200; k++) begin
            axi_rd(REG_STATUS);
            if (d[ST_ACTIVE_BIT] === 1'b1) begin
                n = cyc - t0;
                return;
            end
        end
        n_fail++;
        report_and_stop();
    endtask
    // expected word worked out from offset, clip and format; held four clocks
    task automatic smp(input logic [CORE_W-1:0] c);
        logic signed [DIFF_W-1:0] v;
        v = $signed({1'b0, c}) - $signed({off[CORE_W-1], off});
        if (v > 1023) e = {2'b10, CODE_ONES};
        else if (v < 0) e = {2'b01, CODE_ZERO};
        else e = {2'b00, v[CODE_W-1:0]};
        e[CODE_MSB] = e[CODE_MSB] ^ fmt;
        exp_q.push_back(e);
        last_e = e;
        core <= c;
        repeat (4) @(posedge clk);
        -> got;
    endtask
    // result watcher: oldest note against flags and captured bus
    always @(got) begin
        e = exp_q.pop_front();
        `CHK({ovr, und, bus}, e)
    end
    initial begin
        {awv, wv, br, arv, rr, awa, ara, wd, fmt, core, off, cyc} = '0;
        nrst = 1'b0;
        want = 4'h3;
        seed = 32'h0000_0039;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t0 = cyc;
        wait_act(n_pd);
        axi_rd(REG_STATUS);
        `CHK(d[ST_INIT_BIT], 1'b1)
        axi_rd(REG_OFFSET);
        `CHK({r, d}, {RESP_OKAY, 32'h0000_0000})
        axi_rd(REG_IRQ_ENABLE);
        `CHK({r, d}, {RESP_OKAY, 32'h0000_0000})
        axi_rd(8'h40);
        `CHK(r, RESP_SLVERR)
        axi_wr(REG_STATUS, 32'h0000_0001, RESP_SLVERR);
        off = 12'h020;
        axi_wr(REG_OFFSET, {20'h0_0000, off}, RESP_OKAY);
        axi_wr(REG_IRQ_ENABLE, 32'h0000_0001, RESP_OKAY);
        // both formats: boundary table then random codes
        for (int f = 0; f < 2; f++) begin
            fmt = f[0];
            want.format_select <= fmt;
            repeat (8) @(posedge clk);
            foreach (bnd[i]) begin
                smp(bnd[i]);
            end
            for (int i = 0; i < 6; i++) begin
                seed = xs(seed);
                smp(seed[CORE_W-1:0] & 12'h7ff);
            end
        end
        `CHK(irq, 1'b1)
        core <= 12'h000;
        axi_wr(REG_IRQ_CLEAR, 32'h0000_000f, RESP_OKAY);
        repeat (4) @(posedge clk);
        `CHK(irq, 1'b0)
        want.output_enable_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(oe, 1'b0)
        want.output_enable_n <= 1'b0;
        repeat (8) @(posedge clk);
        off = 12'h800;
        axi_wr(REG_OFFSET, {20'h0_0000, off}, RESP_OKAY);
        smp(12'hfff);
        smp(12'h120);
        want.sleep_request_n <= 1'b0;
        repeat (10) @(posedge clk);
        core <= 12'h300;
        repeat (5) @(posedge clk);
        `CHK(bus, last_e[CODE_W-1:0])
        axi_rd(REG_STATUS);
        `CHK(d[ST_SLEEP_BIT], 1'b1)
        t0 = cyc;
        want.sleep_request_n <= 1'b1;
        wait_act(n_sl);
        `CHK(n_sl < n_pd && n_pd >= PD_WAKE_CYC, 1'b1)
        want.power_down_n <= 1'b0;
        want.sleep_request_n <= 1'b0;
        repeat (10) @(posedge clk);
        axi_rd(REG_STATUS);
        `CHK({d[ST_PDOWN_BIT], d[ST_SLEEP_BIT], oe}, 3'b100)
        report_and_stop();
    end
endmodule

// ==== verilog/aofpm_pkg.sv ====
// shared constants and types of the converter output-format and power-mode block
package aofpm_pkg;
    // sample word
    localparam int CODE_W = 10;
    localparam int CORE_W = 12;
    localparam int DIFF_W = 14;
    localparam int CODE_MSB = CODE_W - 1;
    localparam logic [CODE_W-1:0] CODE_ONES = 10'h3ff;
    localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
    localparam logic [CORE_W-1:0] CODE_MAX = 12'h03ff;

    // timing, wake times in ns and derived cycle counts (rounded up)
    localparam int CLK_PERIOD_NS = 40;
    localparam int PD_WAKE_NS = 10000;
    localparam int SLEEP_WAKE_NS = 200;
    localparam int PD_WAKE_CYC = (PD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_WAKE_CYC = (SLEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_W = 9;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
    localparam logic [CORE_W-1:0] OFFSET_RST = 12'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // status register fields
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_SLEEP_BIT = 1;
    localparam int ST_PDOWN_BIT = 2;
    localparam int ST_WAKE_BIT = 3;
    localparam int ST_INIT_BIT = 4;
    localparam int ST_FMT_BIT = 5;
    localparam int ST_OE_BIT = 6;

    // interrupt events, listed from bit 3 down to bit 0
    localparam int EVT_W = 4;
    typedef struct packed {
        logic pdown;
        logic active;
        logic under;
        logic over;
    } aofpm_evt_t;

    // control pins, listed from bit 3 down to bit 0; reset levels are the idle levels
    localparam int PIN_W = 4;
    localparam logic [PIN_W-1:0] PIN_RST = 4'h7;
    typedef struct packed {
        logic format_select;
        logic output_enable_n;
        logic sleep_request_n;
        logic power_down_n;
    } aofpm_pins_t;

    typedef enum logic [2:0] {
        ST_PDOWN,
        ST_PD_WAKE,
        ST_SLEEP,
        ST_SL_WAKE,
        ST_ACTIVE
    } aofpm_state_t;
endpackage

// ==== verilog/aofpm_sticky.sv ====
// sticky event flags with clear, enable and level interrupt
`timescale 1ns/100ps
module aofpm_sticky #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    // events and software control
    input  wire logic [W-1:0] i_set,
    input  wire logic [W-1:0] i_clr,
    input  wire logic [W-1:0] i_en,
    // flags and interrupt
    output logic      [W-1:0] o_status,
    output logic              o_irq
);
    logic [W-1:0] status_r;
    logic [W-1:0] status_nxt;
    logic         irq_r;

    // set wins over a clear in the same cycle
    assign status_nxt = (status_r & ~i_clr) | i_set;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & i_en);
        end
    end

    assign o_status = status_r;
    assign o_irq    = irq_r;
endmodule

// ==== verilog/aofpm_sync3.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module aofpm_sync3 #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    // pins in
    input  wire logic [W-1:0] i_pin,
    // synchronised out
    output logic      [W-1:0] o_last,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;
    logic [W-1:0] lvl_r;

    // ff1 is read by ff2 only
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ff1_r <= RST;
            ff2_r <= RST;
            ff3_r <= RST;
        end else begin
            ff1_r <= i_pin;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lvl_r <= RST;
        end else begin
            lvl_r <= (lvl_r & ~(ff2_r ^ ff3_r)) ^ ((lvl_r ^ ff3_r) & ~(ff2_r ^ ff3_r)) ^ (lvl_r & (ff2_r ^ ff3_r))
                     ^ (lvl_r & ~(ff2_r ^ ff3_r)) ^ (lvl_r & ~(ff2_r ^ ff3_r));
        end
    end

    assign o_last  = ff3_r;
    assign o_level = lvl_r;
endmodule

// ==== verilog/aofpm_top.sv ====
// output clipping, data format and power-mode control with axi4-lite registers
//
// Function
// - out of range forces all ones or zeros; code: offset binary only, twos complement inverts the top bit
// - centred output clips and flags before max
// - format select low offset, high twos complement
// - offset binary codes per full-scale table
// - twos complement codes per full-scale table
// - power-down overrides everything, stops internal clock
// - power-down wake longer than sleep wake
// - sleep stops internal clocking, fast restart
// - only the rising clock edge is used
// - data outputs float while enable-bar high
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module aofpm_top
    import aofpm_pkg::*;
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    // converter core sample, same clock
    input  wire logic [CORE_W-1:0] i_core_code,
    // control pins from the controller
    input  wire aofpm_pins_t       i_pins,
    // parallel sample output
    output logic      [CODE_W-1:0] o_data,
    output logic                   o_data_oe,
    output logic                   o_over_range,
    output logic                   o_under_range,
    // interrupt
    output logic                   o_irq,
    // axi4-lite write
    input  wire logic              i_axi_awvalid,
    output logic                   o_axi_awready,
    input  wire logic [ADDR_W-1:0] i_axi_awaddr,
    input  wire logic              i_axi_wvalid,
    output logic                   o_axi_wready,
    input  wire logic [DATA_W-1:0] i_axi_wdata,
    input  wire logic [3:0]        i_axi_wstrb,
    output logic                   o_axi_bvalid,
    input  wire logic              i_axi_bready,
    output logic      [1:0]        o_axi_bresp,
    // axi4-lite read
    input  wire logic              i_axi_arvalid,
    output logic                   o_axi_arready,
    input  wire logic [ADDR_W-1:0] i_axi_araddr,
    output logic                   o_axi_rvalid,
    input  wire logic              i_axi_rready,
    output logic      [DATA_W-1:0] o_axi_rdata,
    output logic      [1:0]        o_axi_rresp
);
    aofpm_pins_t               pins_s;
    aofpm_pins_t               pins_last;
    aofpm_state_t              state_r;
    aofpm_state_t              state_nxt;
    logic        [WAKE_W-1:0]  wake_cnt_r;
    logic        [WAKE_W-1:0]  wake_cnt_nxt;
    logic                      init_r;
    logic signed [DIFF_W-1:0]  diff_c;
    logic                      over_c;
    logic                      under_c;
    logic        [CODE_W-1:0]  clip_c;
    logic        [CODE_W-1:0]  code_c;
    logic        [CODE_W-1:0]  data_r;
    logic                      oe_r;
    logic                      over_r;
    logic                      under_r;
    logic        [CORE_W-1:0]  offset_r;
    logic        [EVT_W-1:0]   irq_en_r;
    logic        [EVT_W-1:0]   irq_status;
    logic        [EVT_W-1:0]   irq_clr_c;
    aofpm_evt_t                evt_c;
    logic                      irq;
    logic                      aw_got_r;
    logic                      w_got_r;
    logic        [ADDR_W-1:0]  awaddr_r;
    logic        [DATA_W-1:0]  wdata_r;
    logic        [3:0]         wstrb_r;
    logic                      awready_r;
    logic                      wready_r;
    logic                      bvalid_r;
    logic        [1:0]         bresp_r;
    logic                      arready_r;
    logic                      rvalid_r;
    logic        [DATA_W-1:0]  rdata_r;
    logic        [1:0]         rresp_r;
    logic                      wr_go;
    logic        [DATA_W-1:0]  rd_mux;
    logic                      rd_hit;
    logic                      mode_active;

    // pins come from outside the clock domain
    aofpm_sync3 #(
        .W   (PIN_W),
        .RST (PIN_RST)
    ) u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_pin     (i_pins),
        .o_last    (pins_last),
        .o_level   (pins_s)
    );

    // a one-cycle low on the pin still arms the device, so watch stage three
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            init_r <= 1'b0;
        end else if (!pins_last.power_down_n) begin
            init_r <= 1'b1;
        end
    end

    // mode sequencer, power-down first
    always_comb begin
        state_nxt    = state_r;
        wake_cnt_nxt = wake_cnt_r;
        if (!pins_s.power_down_n || !init_r) begin
            state_nxt    = ST_PDOWN;
            wake_cnt_nxt = '0;
        end else begin
            case (state_r)
                ST_PDOWN: begin
                    state_nxt    = ST_PD_WAKE;
                    wake_cnt_nxt = WAKE_W'(PD_WAKE_CYC - 1);
                end
                ST_PD_WAKE: begin
                    if (wake_cnt_r == '0) begin
                        state_nxt = pins_s.sleep_request_n ? ST_ACTIVE : ST_SLEEP;
                    end else begin
                        wake_cnt_nxt = wake_cnt_r - 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (!pins_s.sleep_request_n) begin
                        state_nxt = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (pins_s.sleep_request_n) begin
                        state_nxt    = ST_SL_WAKE;
                        wake_cnt_nxt = WAKE_W'(SLEEP_WAKE_CYC - 1);
                    end
                end
                ST_SL_WAKE: begin
                    if (!pins_s.sleep_request_n) begin
                        state_nxt = ST_SLEEP;
                    end else if (wake_cnt_r == '0) begin
                        state_nxt = ST_ACTIVE;
                    end else begin
                        wake_cnt_nxt = wake_cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_nxt = ST_PDOWN;
                end
            endcase
        end
    end

    // all timing on the rising edge only
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r    <= ST_PDOWN;
            wake_cnt_r <= '0;
        end else begin
            state_r    <= state_nxt;
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    assign mode_active = (state_r == ST_ACTIVE);

    // offset correction centres the code, so clipping comes before the core's max
    assign diff_c  = $signed({1'b0, i_core_code}) - $signed({offset_r[CORE_W-1], offset_r});
    assign under_c = diff_c[DIFF_W-1];
    // full magnitude compared, a negative offset can push the difference past 12 bits
    assign over_c  = !diff_c[DIFF_W-1] && (diff_c[DIFF_W-2:0] > {1'b0, CODE_MAX});
    assign clip_c  = over_c ? CODE_ONES : (under_c ? CODE_ZERO : diff_c[CODE_W-1:0]);
    // twos complement is offset binary with the top bit inverted
    assign code_c  = pins_s.format_select ? {~clip_c[CODE_MSB], clip_c[CODE_MSB-1:0]} : clip_c;

    // sample register; sleep and power-down freeze it as the internal clock is gated
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            data_r  <= CODE_ZERO;
            over_r  <= 1'b0;
            under_r <= 1'b0;
        end else if (mode_active) begin
            data_r  <= code_c;
            over_r  <= over_c;
            under_r <= under_c;
        end
    end

    // drivers float on enable-bar high, and in power-down nothing drives
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= !pins_s.output_enable_n && (state_nxt != ST_PDOWN);
        end
    end

    // interrupt events
    assign evt_c.over   = mode_active && over_c;
    assign evt_c.under  = mode_active && under_c;
    assign evt_c.active = (state_nxt == ST_ACTIVE) && !mode_active;
    assign evt_c.pdown  = (state_nxt == ST_PDOWN) && (state_r != ST_PDOWN);
    assign irq_clr_c    = (wr_go && awaddr_r == REG_IRQ_CLEAR && wstrb_r[0]) ? wdata_r[EVT_W-1:0] : '0;

    aofpm_sticky #(
        .W (EVT_W)
    ) u_irq (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_set     (evt_c),
        .i_clr     (irq_clr_c),
        .i_en      (irq_en_r),
        .o_status  (irq_status),
        .o_irq     (irq)
    );

    // write channel: address and data taken in either order
    assign wr_go = aw_got_r && w_got_r && !bvalid_r;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (i_axi_awvalid && awready_r) begin
                aw_got_r  <= 1'b1;
                awaddr_r  <= i_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (i_axi_wvalid && wready_r) begin
                w_got_r  <= 1'b1;
                wdata_r  <= i_axi_wdata;
                wstrb_r  <= i_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                case (awaddr_r)
                    REG_OFFSET, REG_IRQ_CLEAR, REG_IRQ_ENABLE: bresp_r <= RESP_OKAY;
                    default:                                   bresp_r <= RESP_SLVERR;
                endcase
            end
            if (bvalid_r && i_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // writable registers with byte lanes
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            offset_r <= OFFSET_RST;
            irq_en_r <= '0;
        end else if (wr_go) begin
            if (awaddr_r == REG_OFFSET && wstrb_r[0]) begin
                offset_r[7:0] <= wdata_r[7:0];
            end
            if (awaddr_r == REG_OFFSET && wstrb_r[1]) begin
                offset_r[CORE_W-1:8] <= wdata_r[CORE_W-1:8];
            end
            if (awaddr_r == REG_IRQ_ENABLE && wstrb_r[0]) begin
                irq_en_r <= wdata_r[EVT_W-1:0];
            end
        end
    end

    // read mux; the clear register is write-only and reads zero
    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (i_axi_araddr)
            REG_STATUS: begin
                rd_mux[ST_ACTIVE_BIT] = mode_active;
                rd_mux[ST_SLEEP_BIT]  = (state_r == ST_SLEEP);
                rd_mux[ST_PDOWN_BIT]  = (state_r == ST_PDOWN);
                rd_mux[ST_WAKE_BIT]   = (state_r == ST_PD_WAKE) || (state_r == ST_SL_WAKE);
                rd_mux[ST_INIT_BIT]   = init_r;
                rd_mux[ST_FMT_BIT]    = pins_s.format_select;
                rd_mux[ST_OE_BIT]     = oe_r;
            end
            REG_OFFSET:     rd_mux[CORE_W-1:0] = offset_r;
            REG_IRQ_STATUS: rd_mux[EVT_W-1:0] = irq_status;
            REG_IRQ_CLEAR:  rd_mux = '0;
            REG_IRQ_ENABLE: rd_mux[EVT_W-1:0] = irq_en_r;
            default:        rd_hit = 1'b0;
        endcase
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else if (i_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && i_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign o_data        = data_r;
    assign o_data_oe     = oe_r;
    assign o_over_range  = over_r;
    assign o_under_range = under_r;
    assign o_irq         = irq;
    assign o_axi_awready = awready_r;
    assign o_axi_wready  = wready_r;
    assign o_axi_bvalid  = bvalid_r;
    assign o_axi_bresp   = bresp_r;
    assign o_axi_arready = arready_r;
    assign o_axi_rvalid  = rvalid_r;
    assign o_axi_rdata   = rdata_r;
    assign o_axi_rresp   = rresp_r;

    // checks on the output stage and sequencer
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    a_over_ones: assert property (mode_active && over_c && !pins_s.format_select |=> o_data == CODE_ONES)
        else $error("overrange not forced to all ones");
    a_under_zeros: assert property (mode_active && under_c && !pins_s.format_select |=> o_data == CODE_ZERO)
        else $error("underrange not forced to all zeros");
    a_clip_flags: assert property (mode_active |=> o_over_range == $past(over_c) && o_under_range == $past(under_c))
        else $error("range flag does not follow clip");
    a_fmt_offset: assert property (mode_active && !over_c && !under_c && !pins_s.format_select
                                   |=> o_data == $past(diff_c[CODE_W-1:0]))
        else $error("offset binary code wrong");
    a_fmt_twos: assert property (mode_active && !over_c && !under_c && pins_s.format_select
                                 |=> o_data == {~$past(diff_c[CODE_MSB]), $past(diff_c[CODE_MSB-1:0])})
        else $error("twos complement code wrong");
    a_pd_override: assert property (!pins_s.power_down_n |=> state_r == ST_PDOWN && !o_data_oe)
        else $error("power-down did not override");
    a_pd_wake_long: assert property ($fell(state_r == ST_PDOWN) |-> (state_r == ST_PD_WAKE)[*8]
                                     or ##[1:8] (state_r == ST_PDOWN))
        else $error("power-down wake too short");
    a_sleep_freeze: assert property (state_r == ST_SLEEP |=> $stable(o_data) && state_r != ST_ACTIVE)
        else $error("sleep did not stop sampling");
    a_oe_follows: assert property (pins_s.output_enable_n |=> !o_data_oe)
        else $error("outputs driven while enable-bar high");
    a_new_sample: assert property (mode_active |=> o_data == $past(code_c))
        else $error("active sample not updated");

    c_reach_active: cover property ($rose(mode_active));
    c_over_range: cover property (mode_active && over_c ##1 mode_active && under_c);
    c_sleep_wake: cover property (state_r == ST_SL_WAKE ##[1:8] mode_active);
    c_pd_entry: cover property (mode_active ##1 state_r == ST_PDOWN);
endmodule
